// ===== lss_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: 10 MHz system clock.
// Notes: Included by the supervisor module.
`ifndef LSS_REGS_SVH
`define LSS_REGS_SVH
`define LSS_ADDR_CTRL 4'h0
`define LSS_ADDR_PARAM 4'h1
`define LSS_ADDR_TIMER 4'h2
`define LSS_ADDR_STATUS 4'h3
`define LSS_ADDR_IRQ 4'h4
`define LSS_ADDR_MASK 4'h5
`define LSS_ADDR_N4 4'h6
`define LSS_POLICY_RST 4'h0
`define LSS_N2_RST 4'h3
`define LSS_N3_RST 4'h1
`define LSS_N1_RST 8'h06
`define LSS_T1_RST 5'h0A
`define LSS_T2_RST 5'h0F
`define LSS_T3_RST 5'h14
`define LSS_N4_RST 8'h05
`define LSS_CLK_HZ 10000000
`define LSS_TICK_CYCLES (`LSS_CLK_HZ / 1)
`define LSS_IRQ_WARN 0
`define LSS_IRQ_ERR 1
`define LSS_IRQ_CLR 2
`define LSS_IRQ_N4 3
`define LSS_IRQ_T2 4
`endif

// ===== lss_pkg.sv
// Purpose: Types for the link management state supervisor.
// Assumes: Constants come from lss_regs.svh.
// Notes: Policy encodings follow the order of the selectable settings.
package lss_pkg;
  typedef enum logic [3:0] {
    LSS_INDEPENDENT = 4'h0,
    LSS_NET_FOLLOWS_P1 = 4'h1,
    LSS_NET_FOLLOWS_P2 = 4'h2,
    LSS_NET_FOLLOWS_RTR = 4'h3,
    LSS_P1_FOLLOWS_NET = 4'h4,
    LSS_P2_FOLLOWS_NET = 4'h5,
    LSS_RTR_FOLLOWS_NET = 4'h6,
    LSS_ALL_PORTS_FOLLOW_NETWORK = 4'h7,
    LSS_P1_CODEP = 4'h8,
    LSS_P2_CODEP = 4'h9,
    LSS_RTR_CODEP = 4'hA
  } lss_policy_type;
  typedef enum logic [1:0] {
    LSS_ST_IDLE = 2'b01,
    LSS_ST_WAIT = 2'b10
  } lss_poll_type;
endpackage : lss_pkg

// ===== lss_supervisor.sv
// Purpose: Couples network and user link management states, runs counters.
// Assumes: Inputs synchronous to clk; link events are one-cycle pulses.
// Notes: Register port reads answer one cycle after the read strobe.
`timescale 1ns/1ps
`include "lss_regs.svh"
// Functional notes
// - Independent policy keeps every interface state separate.
// - Network follows port: port down forces network down and disabled.
// - Network re-enabled when followed port returns; network never affects it.
// - Network follows router port: down while router down, restored after.
// - Port follows network: port down, disabled, leads off on failure.
// - Router follows network: router disabled while network link down.
// - All ports follow network: every data port down while network down.
// - Codependent: either paired side down forces the other down.
// - Policy changes refused while backup enabled; warning shown.
// - Error event raised when error count reaches limit 1 to 10.
// - Error event cleared after configured consecutive good messages.
// - User side makes every n1-th poll a full enquiry.
// - User side starts enquiry every 5 to 30 seconds, default 10.
// - Network side expects enquiries every 5 to 30 seconds, default 15.
// - Network side counts enquiries per window, checks against maximum.
// - Normal mode acts as user side; back-to-back acts as network.
module lss_supervisor
  import lss_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `LSS_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic net_raw_up,
  input wire logic p1_raw_up,
  input wire logic p2_raw_up,
  input wire logic rtr_raw_up,
  input wire logic auto_backup_en,
  input wire logic back_to_back,
  input wire logic lmi_msg_ok,
  input wire logic lmi_msg_err,
  input wire logic enq_rx,
  input wire logic enq_done,
  output logic net_up,
  output logic p1_up,
  output logic p2_up,
  output logic rtr_up,
  output logic net_en,
  output logic p1_en,
  output logic p2_en,
  output logic rtr_en,
  output logic enq_start,
  output logic enq_full,
  output logic policy_warn,
  output logic irq
);
  typedef struct packed {
    lss_policy_type policy;
    logic [3:0] n2;
    logic [3:0] n3;
    logic [7:0] n1;
    logic [4:0] t1;
    logic [4:0] t2;
    logic [4:0] t3;
    logic [7:0] n4;
    logic [23:0] div;
    logic tick;
    logic [3:0] err_cnt;
    logic [3:0] ok_cnt;
    logic err_event;
    logic [7:0] poll_cnt;
    logic [4:0] hb_cnt;
    lss_poll_type poll_st;
    logic [4:0] in_cnt;
    logic [4:0] win_cnt;
    logic [7:0] enq_cnt;
    logic [7:0] enq_last;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic enq_start;
    logic enq_full;
    logic [31:0] rdata;
  } lss_state_type;

  lss_state_type s;
  lss_state_type next_s;
  logic net_f;
  logic p1_f;
  logic p2_f;
  logic rtr_f;
  logic user_side;
  logic [4:0] ev;
  logic t1_ok;
  logic t2_ok;
  logic t3_ok;

  // ----------------------------------------------------------------
  // Link coupling policy
  // ----------------------------------------------------------------
  always_comb begin
    net_f = net_raw_up;
    p1_f = p1_raw_up;
    p2_f = p2_raw_up;
    rtr_f = rtr_raw_up;
    case (s.policy)
      LSS_INDEPENDENT: begin
        net_f = net_raw_up;
      end
      LSS_NET_FOLLOWS_P1: begin
        net_f = net_raw_up & p1_raw_up;
      end
      LSS_NET_FOLLOWS_P2: begin
        net_f = net_raw_up & p2_raw_up;
      end
      LSS_NET_FOLLOWS_RTR: begin
        net_f = net_raw_up & rtr_raw_up;
      end
      LSS_P1_FOLLOWS_NET: begin
        p1_f = p1_raw_up & net_raw_up;
      end
      LSS_P2_FOLLOWS_NET: begin
        p2_f = p2_raw_up & net_raw_up;
      end
      LSS_RTR_FOLLOWS_NET: begin
        rtr_f = rtr_raw_up & net_raw_up;
      end
      LSS_ALL_PORTS_FOLLOW_NETWORK: begin
        p1_f = p1_raw_up & net_raw_up;
        p2_f = p2_raw_up & net_raw_up;
      end
      LSS_P1_CODEP: begin
        net_f = net_raw_up & p1_raw_up;
        p1_f = p1_raw_up & net_raw_up;
      end
      LSS_P2_CODEP: begin
        net_f = net_raw_up & p2_raw_up;
        p2_f = p2_raw_up & net_raw_up;
      end
      LSS_RTR_CODEP: begin
        net_f = net_raw_up & rtr_raw_up;
        rtr_f = rtr_raw_up & net_raw_up;
      end
      default: begin
        net_f = net_raw_up;
      end
    endcase
  end

  // Forced-down interfaces are disabled, which also drops their leads.
  assign net_up = net_f;
  assign p1_up = p1_f;
  assign p2_up = p2_f;
  assign rtr_up = rtr_f;
  assign net_en = net_f;
  assign p1_en = p1_f;
  assign p2_en = p2_f;
  assign rtr_en = rtr_f;
  assign user_side = ~back_to_back;
  assign policy_warn = auto_backup_en;
  assign enq_start = s.enq_start;
  assign enq_full = s.enq_full;
  assign reg_rdata = s.rdata;
  assign irq = |(s.irq_stat & s.irq_mask);

  // ----------------------------------------------------------------
  // Timer field checks
  // ----------------------------------------------------------------
  // Timer fields take only multiples of five seconds from 5 to 30; any other
  // value leaves the field as it was.
  always_comb begin
    t1_ok = 1'b0;
    t2_ok = 1'b0;
    t3_ok = 1'b0;
    case (reg_wdata[4:0])
      5'h05, 5'h0A, 5'h0F, 5'h14, 5'h19, 5'h1E: begin
        t1_ok = 1'b1;
      end
      default: begin
        t1_ok = 1'b0;
      end
    endcase
    case (reg_wdata[9:5])
      5'h05, 5'h0A, 5'h0F, 5'h14, 5'h19, 5'h1E: begin
        t2_ok = 1'b1;
      end
      default: begin
        t2_ok = 1'b0;
      end
    endcase
    case (reg_wdata[14:10])
      5'h05, 5'h0A, 5'h0F, 5'h14, 5'h19, 5'h1E: begin
        t3_ok = 1'b1;
      end
      default: begin
        t3_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State update
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    ev = 5'h00;
    next_s.enq_start = 1'b0;
    next_s.enq_full = 1'b0;
    next_s.rdata = 32'h0000_0000;
    // One-second tick.
    next_s.tick = 1'b0;
    if (s.div == 24'(TICK_CYCLES - 1)) begin
      next_s.div = 24'h00_0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 24'h00_0001;
    end
    // Error and clearing counters.
    // An errored message wins over a good one in the same cycle.
    if (lmi_msg_err) begin
      next_s.ok_cnt = 4'h0;
      if (!s.err_event) begin
        if (s.err_cnt + 4'h1 >= s.n2) begin
          next_s.err_event = 1'b1;
          next_s.err_cnt = 4'h0;
          ev[`LSS_IRQ_ERR] = 1'b1;
        end else begin
          next_s.err_cnt = s.err_cnt + 4'h1;
        end
      end
    end else if (lmi_msg_ok) begin
      next_s.err_cnt = 4'h0;
      if (s.err_event) begin
        if (s.ok_cnt + 4'h1 >= s.n3) begin
          next_s.err_event = 1'b0;
          next_s.ok_cnt = 4'h0;
          ev[`LSS_IRQ_CLR] = 1'b1;
        end else begin
          next_s.ok_cnt = s.ok_cnt + 4'h1;
        end
      end
    end
    // User-side polling.
    // Heartbeat ticks are not counted while an enquiry is outstanding.
    case (s.poll_st)
      LSS_ST_IDLE: begin
        if (user_side && s.tick) begin
          if (s.hb_cnt + 5'h01 >= s.t1) begin
            next_s.hb_cnt = 5'h00;
            next_s.enq_start = 1'b1;
            next_s.poll_st = LSS_ST_WAIT;
            if (s.poll_cnt + 8'h01 >= s.n1) begin
              next_s.poll_cnt = 8'h00;
              next_s.enq_full = 1'b1;
            end else begin
              next_s.poll_cnt = s.poll_cnt + 8'h01;
            end
          end else begin
            next_s.hb_cnt = s.hb_cnt + 5'h01;
          end
        end
      end
      LSS_ST_WAIT: begin
        if (enq_done || !user_side) begin
          next_s.poll_st = LSS_ST_IDLE;
        end
      end
      default: begin
        next_s.poll_st = LSS_ST_IDLE;
      end
    endcase
    // Network-side inbound heartbeat and measurement window.
    if (!user_side) begin
      if (enq_rx) begin
        next_s.in_cnt = 5'h00;
        next_s.enq_cnt = s.enq_cnt + 8'h01;
      end else if (s.tick) begin
        if (s.in_cnt + 5'h01 >= s.t2) begin
          next_s.in_cnt = 5'h00;
          ev[`LSS_IRQ_T2] = 1'b1;
        end else begin
          next_s.in_cnt = s.in_cnt + 5'h01;
        end
      end
      if (s.tick) begin
        // An enquiry on the closing tick still counts for this window.
        if (s.win_cnt + 5'h01 >= s.t3) begin
          next_s.win_cnt = 5'h00;
          next_s.enq_last = s.enq_cnt + {7'h00, enq_rx};
          next_s.enq_cnt = 8'h00;
          if (s.enq_cnt + {7'h00, enq_rx} > s.n4) begin
            ev[`LSS_IRQ_N4] = 1'b1;
          end
        end else begin
          next_s.win_cnt = s.win_cnt + 5'h01;
        end
      end
    end
    // Register port.
    // Read data stand for one cycle only and are zero otherwise.
    if (reg_rd) begin
      case (reg_addr)
        `LSS_ADDR_CTRL: next_s.rdata = {28'h0, s.policy};
        `LSS_ADDR_PARAM: next_s.rdata = {16'h0, s.n1, s.n3, s.n2};
        `LSS_ADDR_TIMER: next_s.rdata = {17'h0, s.t3, s.t2, s.t1};
        `LSS_ADDR_STATUS: next_s.rdata = {16'h0, s.enq_last, 1'b0,
          user_side, auto_backup_en, s.err_event, rtr_f, p2_f, p1_f, net_f};
        `LSS_ADDR_IRQ: next_s.rdata = {27'h0, s.irq_stat};
        `LSS_ADDR_MASK: next_s.rdata = {27'h0, s.irq_mask};
        `LSS_ADDR_N4: next_s.rdata = {24'h0, s.n4};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (reg_wr) begin
      case (reg_addr)
        `LSS_ADDR_CTRL: begin
          if (auto_backup_en) begin
            ev[`LSS_IRQ_WARN] = 1'b1;
          end else if (reg_wdata[3:0] <= 4'hA) begin
            next_s.policy = lss_policy_type'(reg_wdata[3:0]);
          end
        end
        `LSS_ADDR_PARAM: begin
          if (reg_wdata[3:0] >= 4'h1 && reg_wdata[3:0] <= 4'hA) begin
            next_s.n2 = reg_wdata[3:0];
          end
          if (reg_wdata[7:4] >= 4'h1 && reg_wdata[7:4] <= 4'hA) begin
            next_s.n3 = reg_wdata[7:4];
          end
          if (reg_wdata[15:8] != 8'h00) begin
            next_s.n1 = reg_wdata[15:8];
          end
        end
        `LSS_ADDR_TIMER: begin
          if (t1_ok) begin
            next_s.t1 = reg_wdata[4:0];
          end
          if (t2_ok) begin
            next_s.t2 = reg_wdata[9:5];
          end
          if (t3_ok) begin
            next_s.t3 = reg_wdata[14:10];
          end
        end
        `LSS_ADDR_IRQ: next_s.irq_stat = s.irq_stat & ~reg_wdata[4:0];
        `LSS_ADDR_MASK: next_s.irq_mask = reg_wdata[4:0];
        `LSS_ADDR_N4: next_s.n4 = reg_wdata[7:0];
        default: next_s.n4 = s.n4;
      endcase
    end
    // Set wins over a clear in the same cycle.
    next_s.irq_stat = next_s.irq_stat | ev;
  end

  // Reset restores every timer, counter and setting to its default.
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.policy <= lss_policy_type'(`LSS_POLICY_RST);
      s.n2 <= `LSS_N2_RST;
      s.n3 <= `LSS_N3_RST;
      s.n1 <= `LSS_N1_RST;
      s.t1 <= `LSS_T1_RST;
      s.t2 <= `LSS_T2_RST;
      s.t3 <= `LSS_T3_RST;
      s.n4 <= `LSS_N4_RST;
      s.poll_st <= LSS_ST_IDLE;
    end else begin
      s <= next_s;
    end
  end
endmodule : lss_supervisor

// ===== lss_supervisor_asserts.sv
// Purpose: Port-level checks for the link management state supervisor.
// Assumes: Single clock domain, synchronous active-high reset.
// Notes: Bound to every instance of lss_supervisor.
`timescale 1ns/1ps
module lss_supervisor_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic net_raw_up,
  input wire logic p1_raw_up,
  input wire logic p2_raw_up,
  input wire logic rtr_raw_up,
  input wire logic auto_backup_en,
  input wire logic back_to_back,
  input wire logic net_up,
  input wire logic p1_up,
  input wire logic p2_up,
  input wire logic rtr_up,
  input wire logic net_en,
  input wire logic p1_en,
  input wire logic p2_en,
  input wire logic rtr_en,
  input wire logic enq_start,
  input wire logic enq_full,
  input wire logic policy_warn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence start_pulse;
    enq_start ##1 !enq_start;
  endsequence
  chk_enable_tracks_up: assert property ({net_en, p1_en, p2_en, rtr_en} == {net_up, p1_up, p2_up, rtr_up})
    else $error("enable differs from up state");
  chk_warn_backup: assert property (policy_warn == auto_backup_en)
    else $error("warning differs from backup enable");
  chk_net_raw: assert property (net_up |-> net_raw_up)
    else $error("network up while its own link is down");
  chk_port_raw: assert property ((p1_up || p2_up) |-> (!p1_up || p1_raw_up) && (!p2_up || p2_raw_up))
    else $error("data port up while its own link is down");
  chk_rtr_raw: assert property (rtr_up |-> rtr_raw_up)
    else $error("router port up while its own link is down");
  chk_full_start: assert property (enq_full |-> enq_start)
    else $error("full enquiry without an enquiry start");
  chk_start_pulse: assert property (enq_start |-> start_pulse)
    else $error("enquiry start longer than one cycle");
  chk_net_quiet: assert property (back_to_back && $past(back_to_back) |-> !enq_start)
    else $error("enquiry started while acting as network side");
endmodule : lss_supervisor_chk
bind lss_supervisor lss_supervisor_chk chk_u (.clk(clk), .rst(rst),
  .net_raw_up(net_raw_up), .p1_raw_up(p1_raw_up), .p2_raw_up(p2_raw_up),
  .rtr_raw_up(rtr_raw_up), .auto_backup_en(auto_backup_en),
  .back_to_back(back_to_back), .net_up(net_up), .p1_up(p1_up),
  .p2_up(p2_up), .rtr_up(rtr_up), .net_en(net_en), .p1_en(p1_en),
  .p2_en(p2_en), .rtr_en(rtr_en), .enq_start(enq_start),
  .enq_full(enq_full), .policy_warn(policy_warn));

// ===== lss_far_end.sv
// Purpose: Far-end link partner answering and issuing status enquiries.
// Assumes: Gaps and reply delays are given in clock cycles.
// Notes: A poll gap of zero stops the partner issuing enquiries; it still answers.
`timescale 1ns/1ps
module lss_far_end (
  input wire logic clk,
  input wire logic rst,
  input wire logic enq_start,
  input wire logic [15:0] poll_gap,
  input wire logic [7:0] reply_wait,
  output logic enq_done,
  output logic enq_rx
);
  logic [15:0] gap_cnt;
  logic [7:0] wait_cnt;
  logic busy;
  always @(posedge clk) begin
    enq_done <= 1'b0;
    enq_rx <= 1'b0;
    if (rst) begin
      gap_cnt <= 16'h0;
      wait_cnt <= 8'h0;
      busy <= 1'b0;
    end else begin
      if (enq_start) begin
        busy <= 1'b1;
        wait_cnt <= reply_wait;
      end else if (busy && wait_cnt == 8'h0) begin
        enq_done <= 1'b1;
        busy <= 1'b0;
      end else if (busy) begin
        wait_cnt <= wait_cnt - 8'h1;
      end
      if (poll_gap != 16'h0 && gap_cnt >= poll_gap - 16'h1) begin
        gap_cnt <= 16'h0;
        enq_rx <= 1'b1;
      end else if (poll_gap != 16'h0) begin
        gap_cnt <= gap_cnt + 16'h1;
      end
    end
  end
endmodule : lss_far_end

// ===== tb.sv
// Purpose: Self-checking bench for the link management state supervisor.
// Assumes: One second is shortened to 10 clock cycles.
// Notes: Raw link bits are ordered router, port 2, port 1, network.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic auto_backup_en = 1'b0, back_to_back = 1'b0;
  logic lmi_msg_ok = 1'b0, lmi_msg_err = 1'b0;
  logic [3:0] reg_addr = 4'h0, raw = 4'hF, up, en;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [15:0] poll_gap = 16'h0;
  logic [7:0] reply_wait = 8'h0;
  logic enq_rx, enq_done, enq_start, enq_full, policy_warn, irq;
  int num_errors = 0, check_count = 0;
  int poll_wait = 0;
  always #50 clk = ~clk;
  lss_supervisor #(.TICK_CYCLES(10)) dut_u (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .net_raw_up(raw[0]),
    .p1_raw_up(raw[1]), .p2_raw_up(raw[2]), .rtr_raw_up(raw[3]),
    .auto_backup_en(auto_backup_en), .back_to_back(back_to_back),
    .lmi_msg_ok(lmi_msg_ok), .lmi_msg_err(lmi_msg_err), .enq_rx(enq_rx),
    .enq_done(enq_done), .net_up(up[0]), .p1_up(up[1]), .p2_up(up[2]),
    .rtr_up(up[3]), .net_en(en[0]), .p1_en(en[1]), .p2_en(en[2]),
    .rtr_en(en[3]), .enq_start(enq_start), .enq_full(enq_full),
    .policy_warn(policy_warn), .irq(irq));
  lss_far_end far_u (.clk(clk), .rst(rst), .enq_start(enq_start),
    .poll_gap(poll_gap), .reply_wait(reply_wait), .enq_done(enq_done),
    .enq_rx(enq_rx));
  // ----------------------------------------
  // Expected states, access tasks, verdict.
  // ----------------------------------------
  function automatic logic [3:0] eff(input int p, input logic [3:0] r);
    logic [3:0] e;
    e = r;
    case (p)
      1, 8: e = (p == 8) ? {r[3:2], {2{r[0] & r[1]}}} : {r[3:1], r[0] & r[1]};
      2, 9: e = (p == 9) ? {r[3], r[2] & r[0], r[1], r[2] & r[0]} : {r[3:1], r[0] & r[2]};
      3, 10: e = (p == 10) ? {{2'b0, r[0]} & 3'b0, 1'b0} | {r[3] & r[0], r[2:1], r[3] & r[0]} : {r[3:1], r[0] & r[3]};
      4: e[1] = r[1] & r[0];
      5: e[2] = r[2] & r[0];
      6: e[3] = r[3] & r[0];
      7: e[2:1] = r[2:1] & {2{r[0]}};
      default: e = r;
    endcase
    return e;
  endfunction : eff
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata & m, e);
  endtask : rd
  task msg(input logic bad);
    @(posedge clk);
    lmi_msg_err <= bad;
    lmi_msg_ok <= !bad;
    @(posedge clk);
    {lmi_msg_err, lmi_msg_ok} <= 2'b00;
  endtask : msg
  task summarize;
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(4'h1, 32'hFFFF, 32'h0613);
    rd(4'h2, 32'h7FFF, 32'h51EA);
    rd(4'h7, 32'hFFFFFFFF, 32'h0);
    for (int p = 0; p < 11; p++) begin
      wr(4'h0, 32'(p));
      for (int r = 0; r < 16; r++) begin
        @(posedge clk);
        raw <= r[3:0];
        @(posedge clk);
        #1;
        chk({28'h0, up}, {28'h0, eff(p, r[3:0])});
        chk({28'h0, en}, {28'h0, eff(p, r[3:0])});
      end
    end
    wr(4'h0, 32'hB);
    @(posedge clk);
    raw <= 4'hF;
    auto_backup_en <= 1'b1;
    wr(4'h5, 32'h7);
    wr(4'h0, 32'h1);
    chk(32'(policy_warn), 32'h1);
    rd(4'h0, 32'hF, 32'hA);
    chk(32'(irq), 32'h1);
    wr(4'h4, 32'h1);
    #1;
    chk(32'(irq), 32'h0);
    auto_backup_en <= 1'b0;
    msg(1'b1);
    msg(1'b1);
    rd(4'h3, 32'h10, 32'h0);
    msg(1'b1);
    rd(4'h3, 32'h10, 32'h10);
    msg(1'b0);
    rd(4'h3, 32'h10, 32'h0);
    rd(4'h4, 32'h6, 32'h6);
    @(posedge clk);
    rst <= 1'b1;
    reply_wait <= 8'h5;
    @(posedge clk);
    rst <= 1'b0;
    wr(4'h1, 32'h0213);
    wr(4'h2, 32'h51E3);
    wr(4'h2, 32'h51E7);
    rd(4'h2, 32'h1F, 32'h0A);
    wr(4'h2, 32'h51E5);
    for (int i = 0; i < 4; i++) begin
      poll_wait = 0;
      @(posedge clk);
      #1;
      while (poll_wait < 300 && enq_start !== 1'b1) begin
        @(posedge clk);
        #1;
        poll_wait++;
      end
      chk({enq_start, enq_full}, {1'b1, i[0]});
      if (i > 0) chk(32'(poll_wait >= 40 && poll_wait <= 70), 32'h1);
    end
    @(posedge clk);
    back_to_back <= 1'b1;
    wr(4'h6, 32'h1);
    wr(4'h4, 32'h1F);
    repeat (170) @(posedge clk);
    rd(4'h4, 32'h10, 32'h10);
    poll_gap <= 16'd20;
    wr(4'h4, 32'h1F);
    repeat (420) @(posedge clk);
    rd(4'h4, 32'h18, 32'h08);
    rd(4'h3, 32'hFF40, 32'h0A00);
    summarize();
  end
  initial begin
    repeat (8000) @(posedge clk);
    num_errors++;
    summarize();
  end
endmodule : tb
